/* sim/storage_model.sv */
`timescale 1ns/1ps
module storage_model
    import load_unit_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Request side
    input wire logic mem_valid,
    input wire mem_req_t mem_req,
    input wire logic [3:0] wait_cycles,
    // Answer side
    output logic mem_ack,
    output logic [31:0] mem_rdata
);
    logic [3:0] cnt_q;

    function automatic logic [7:0] byte_at(input logic [31:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3c;
    endfunction : byte_at

    // Data toggles outside the ack so a stale word never passes for a fresh one
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            mem_ack <= 1'b0;
            cnt_q <= 4'h0;
            mem_rdata <= 32'h0000_0000;
        end else if (!mem_valid || mem_ack) begin
            mem_ack <= 1'b0;
            cnt_q <= wait_cycles;
            mem_rdata <= ~mem_rdata;
        end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
            mem_rdata <= ~mem_rdata;
        end else begin
            mem_ack <= 1'b1;
            mem_rdata <= {byte_at(mem_req.addr), byte_at(mem_req.addr + 32'h1),
                byte_at(mem_req.addr + 32'h2), byte_at(mem_req.addr + 32'h3)};
        end
    end
endmodule : storage_model

/* sim/testbench.sv */
`timescale 1ns/1ps
module testbench
    import load_unit_pkg::*;
;
    logic clock;
    logic rst_n = 1'b0;
    logic cmd_valid = 1'b0;
    load_cmd_t cmd = '0;
    logic abort = 1'b0;
    logic [3:0] wait_cycles = 4'h0;
    logic cmd_ready, mem_valid, mem_ack, invalid_form, condition_field_zero_write, done;
    logic [4:0] rd_base_num, rd_index_num;
    logic [31:0] mem_rdata, rd_base_data, rd_index_data;
    mem_req_t mem_req;
    reg_write_t wr_a, wr_b;
    logic [31:0] general_register [32];
    logic [31:0] seed = 32'hacd10395;
    logic [36:0] got_w[$], exp_w[$];
    logic [33:0] got_m[$], exp_m[$];
    logic got_inv, got_cfz, got_done, exp_inv, exp_cfz;
    int failures = 0;
    int tests_run = 0;

    load_halfword_multi_string_unit load_halfword_multi_string_unit_inst (.clock(clock),
        .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
        .rd_base_num(rd_base_num), .rd_index_num(rd_index_num), .rd_base_data(rd_base_data),
        .rd_index_data(rd_index_data), .mem_valid(mem_valid), .mem_req(mem_req),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .abort(abort), .wr_a(wr_a), .wr_b(wr_b),
        .invalid_form(invalid_form), .done(done),
        .condition_field_zero_write(condition_field_zero_write));
    storage_model storage_model_inst (.clock(clock), .rst_n(rst_n), .mem_valid(mem_valid),
        .mem_req(mem_req), .wait_cycles(wait_cycles), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

    // Register file contents stay fixed, so base and index never move mid-instruction
    assign rd_base_data = general_register[rd_base_num];
    assign rd_index_data = general_register[rd_index_num];

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    always @(posedge clock) begin
        if (wr_a.en) got_w.push_back({wr_a.num, wr_a.data});
        if (wr_b.en) got_w.push_back({wr_b.num, wr_b.data});
        if (mem_valid && mem_ack) got_m.push_back({mem_req.size_m1, mem_req.addr});
        if (invalid_form) got_inv = 1'b1;
        if (condition_field_zero_write) got_cfz = 1'b1;
        if (done) got_done = 1'b1;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    function automatic logic [31:0] word_at(input logic [31:0] a);
        logic [31:0] w;
        logic [31:0] b;
        w = '0;
        // Each byte is keyed on the low sixteen bits of its own address, carries into the upper byte included
        for (int i = 0; i < 4; i++) begin
            b = a + 32'(i);
            w[31 - 8 * i -: 8] = b[7:0] ^ b[15:8] ^ 8'h3c;
        end
        return w;
    endfunction : word_at

    function automatic int byte_total(input load_cmd_t c);
        if (c.op == op_lswi) return (c.immediate_byte_count == 5'h00) ? 32 : c.immediate_byte_count;
        return (c.op == op_lmw) ? 4 * (32 - c.target_register) : 2;
    endfunction : byte_total

    function automatic load_cmd_t mk(input load_op_t o, input logic [4:0] t, input logic [4:0] b,
            input logic [15:0] d, input logic [4:0] n);
        load_cmd_t c;
        c = '0;
        c.op = o;
        c.target_register = t;
        c.base_register = b;
        c.displacement = d;
        c.immediate_byte_count = n;
        return c;
    endfunction : mk

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic build(input load_cmd_t c);
        logic [31:0] base, start_addr, w;
        logic idx, upd;
        int n;
        exp_w = {};
        exp_m = {};
        base = (c.base_register == 5'h00) ? 32'h0 : general_register[c.base_register];
        idx = c.op inside {op_lhax, op_lhaux, op_lhzx, op_lhzux, op_lhbrx};
        upd = c.op inside {op_lhau, op_lhaux, op_lhzu, op_lhzux};
        start_addr = base + (idx ? general_register[c.index_register]
            : {{16{c.displacement[15]}}, c.displacement});
        if (c.op == op_lswi) start_addr = base;
        exp_inv = upd && (c.base_register == 5'h00 || c.base_register == c.target_register);
        exp_cfz = idx && c.record_bit;
        n = byte_total(c);
        if (c.op inside {op_lmw, op_lswi}) begin
            for (int k = 0; k < (n + 3) / 4; k++) begin
                w = word_at(start_addr + 32'(4 * k));
                if (n - 4 * k < 4) w = w & ~(32'hffffffff >> (8 * (n - 4 * k)));
                exp_m.push_back({2'h3, start_addr + 32'(4 * k)});
                exp_w.push_back({5'(c.target_register + k), w});
            end
        end else if (!exp_inv) begin
            w = word_at(start_addr);
            exp_m.push_back({2'h1, start_addr});
            if (c.op inside {op_lha, op_lhau, op_lhax, op_lhaux}) w = {{16{w[31]}}, w[31:16]};
            else if (c.op == op_lhbrx) w = {16'h0, w[23:16], w[31:24]};
            else w = {16'h0, w[31:16]};
            exp_w.push_back({c.target_register, w});
            if (upd) exp_w.push_back({c.base_register, start_addr});
        end
    endtask : build

    task automatic issue(input load_cmd_t c, input logic [3:0] w);
        int k;
        build(c);
        @(negedge clock);
        got_w = {};
        got_m = {};
        {got_inv, got_cfz, got_done} = 3'b000;
        wait_cycles = w;
        cmd = c;
        cmd_valid = 1'b1;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (cmd_ready !== 1'b1 && k < 50);
        @(negedge clock);
        cmd_valid = 1'b0;
    endtask : issue

    task automatic run(input load_cmd_t c, input logic [3:0] w);
        int k;
        issue(c, w);
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (done !== 1'b1 && k < 400);
        @(negedge clock);
        check(got_done, 1'b1);
        check(got_m.size(), exp_m.size());
        foreach (exp_m[i]) check(got_m[i], exp_m[i]);
        check(got_w.size(), exp_w.size());
        foreach (exp_w[i]) check(got_w[i], exp_w[i]);
        check(got_inv, exp_inv);
        if (!exp_inv) check(got_cfz, exp_cfz);
    endtask : run

    task automatic report_and_stop();
        if (failures == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop

    initial begin
        #800000;
        failures++;
        report_and_stop();
    end

    initial begin
        load_cmd_t c;
        logic [31:0] r;
        int regs;
        for (int i = 0; i < 32; i++) general_register[i] = rnd();
        repeat (5) @(posedge clock);
        @(negedge clock);
        rst_n = 1'b1;
        run(mk(op_lhzu, 5'h04, 5'h00, 16'h0010, 5'h00), 4'h0);
        run(mk(op_lhaux, 5'h06, 5'h06, 16'h0000, 5'h00), 4'h1);
        run(mk(op_lha, 5'h02, 5'h00, 16'h8000, 5'h00), 4'h0);
        run(mk(op_lmw, 5'h1f, 5'h00, 16'h8000, 5'h00), 4'h2);
        run(mk(op_lswi, 5'h1e, 5'h09, 16'h0000, 5'h00), 4'h0);
        run(mk(op_lswi, 5'h1f, 5'h02, 16'h0000, 5'h05), 4'h3);
        run(mk(op_lswi, 5'h07, 5'h00, 16'h0000, 5'h03), 4'h0);
        for (int i = 0; i < 60; i++) begin
            r = rnd();
            c = mk(load_op_t'(r[3:0] % 4'd9), r[8:4], r[13:9], r[31:16], r[24:20]);
            c.index_register = r[18:14];
            c.record_bit = r[19];
            run(c, {2'b00, r[26:25]});
        end
        for (int i = 0; i < 40; i++) begin
            r = rnd();
            c = mk(i[0] ? op_lswi : op_lmw, r[4:0], r[9:5], r[31:16], r[14:10]);
            if (c.op == op_lmw && c.target_register == 5'h00) c.target_register = 5'h01;
            regs = (byte_total(c) + 3) / 4;
            // Base kept outside the destination range; software owes that
            while (5'(c.base_register - c.target_register) < regs) c.base_register++;
            run(c, {2'b00, r[11:10]});
        end
        c = mk(op_lmw, 5'h1c, 5'h01, 16'h0000, 5'h00);
        issue(c, 4'h3);
        for (int k = 0; k < 50 && got_w.size() == 0; k++) @(posedge clock);
        @(negedge clock);
        abort = 1'b1;
        @(negedge clock);
        abort = 1'b0;
        for (int k = 0; k < 20 && cmd_ready !== 1'b1; k++) @(negedge clock);
        check(got_w.size(), 1);
        check(got_done, 1'b0);
        run(c, 4'h0);
        report_and_stop();
    end
endmodule : testbench

/* src/load_addr_gen.sv */
`timescale 1ns/1ps
module load_addr_gen
    import load_unit_pkg::*;
(
    // Operands
    input wire logic [4:0] base_field,
    input wire logic [31:0] base_value,
    input wire logic [31:0] index_value,
    input wire logic [15:0] displacement,
    // Form selection
    input wire logic use_index,
    input wire logic use_disp,
    // Result
    output logic [31:0] effective_address
);
    logic [31:0] base_eff;
    logic [31:0] offset;

    always_comb begin
        base_eff = (base_field == REG_ZERO) ? WORD_ZERO : base_value;
        if (use_index) begin
            offset = index_value;
        end else if (use_disp) begin
            offset = {{16{displacement[15]}}, displacement};
        end else begin
            offset = WORD_ZERO;
        end
        effective_address = base_eff + offset;
    end
endmodule : load_addr_gen

/* src/load_halfword_multi_string_unit.sv */
`timescale 1ns/1ps
// Behaviour
// - Indexed forms add base value and full index register contents.
// - Base field zero means base value constant zero, not register zero.
// - Displacement forms sign-extend the sixteen-bit displacement before adding.
// - Update forms write address back to base; zero or equal-target base invalid.
// - Algebraic halfword loads sign-extend the fetched halfword to 32 bits.
// - Zero-extending halfword loads clear the upper sixteen bits.
// - Byte-reversed halfword load swaps the two bytes, then zero-extends.
// - Record bit set on X-forms leaves condition field zero undefined.
// - Load-multiple fills target register through register 31 from consecutive words.
// - Load-multiple may be aborted midway and restarted from the beginning.
// - String load address is base contents alone, or zero for field zero.
// - String load byte count comes from the immediate; zero means 32.
// - String load packs bytes four per register until the count runs out.
// - Lowest-addressed byte goes to the most significant byte position.
// - Bits right of the last loaded byte in the final register are zero.
// - String destination registers wrap from register 31 to register zero.
module load_halfword_multi_string_unit
    import load_unit_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Command from issue
    input wire logic cmd_valid,
    input wire load_cmd_t cmd,
    output logic cmd_ready,
    // Register file read ports
    output logic [4:0] rd_base_num,
    output logic [4:0] rd_index_num,
    input wire logic [31:0] rd_base_data,
    input wire logic [31:0] rd_index_data,
    // Storage access
    output logic mem_valid,
    output mem_req_t mem_req,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    // Abort from interrupt logic
    input wire logic abort,
    // Results
    output reg_write_t wr_a,
    output reg_write_t wr_b,
    output logic invalid_form,
    output logic condition_field_zero_write,
    output logic done
);

    typedef struct packed {
        load_state_t state;
        load_cmd_t cmd;
        logic [31:0] addr;
        logic [4:0] dest;
        logic [5:0] remain;
        logic cmd_ready;
        logic [4:0] rd_base_num;
        logic [4:0] rd_index_num;
        logic mem_valid;
        mem_req_t mem_req;
        reg_write_t wr_a;
        reg_write_t wr_b;
        logic invalid_form;
        logic condition_field_zero_write;
        logic done;
    } unit_state_t;

    unit_state_t s_q;
    unit_state_t s_d;
    logic [31:0] effective_address;
    logic use_index;
    logic use_disp;

    function automatic logic is_update(input load_op_t op);
        return op inside {op_lhau, op_lhaux, op_lhzu, op_lhzux};
    endfunction : is_update

    function automatic logic is_xform(input load_op_t op);
        return op inside {op_lhax, op_lhaux, op_lhzx, op_lhzux, op_lhbrx};
    endfunction : is_xform

    // Bytes in the next string word, capped at four
    function automatic logic [2:0] chunk(input logic [5:0] remain);
        return (remain > WORD_BYTES) ? WORD_BYTES[2:0] : remain[2:0];
    endfunction : chunk

    assign use_index = is_xform(s_q.cmd.op);
    assign use_disp = !(s_q.cmd.op inside {op_lswi}) && !use_index;

    load_addr_gen u_addr (
        .base_field(s_q.cmd.base_register),
        .base_value(rd_base_data),
        .index_value(rd_index_data),
        .displacement(s_q.cmd.displacement),
        .use_index(use_index),
        .use_disp(use_disp),
        .effective_address(effective_address)
    );

    always_comb begin
        logic [15:0] half;
        logic [31:0] word;
        logic [2:0] n;
        half = 16'h0000;
        word = WORD_ZERO;
        n = chunk(s_q.remain);
        s_d = s_q;
        s_d.wr_a.en = 1'b0;
        s_d.wr_b.en = 1'b0;
        s_d.done = 1'b0;
        s_d.invalid_form = 1'b0;
        s_d.condition_field_zero_write = 1'b0;
        case (s_q.state)
            st_idle: begin
                s_d.cmd_ready = 1'b1;
                if (cmd_valid && s_q.cmd_ready) begin
                    s_d.cmd = cmd;
                    s_d.cmd_ready = 1'b0;
                    s_d.rd_base_num = cmd.base_register;
                    s_d.rd_index_num = cmd.index_register;
                    s_d.dest = cmd.target_register;
                    s_d.remain = (cmd.immediate_byte_count == REG_ZERO) ?
                        STRING_FULL_COUNT : {1'b0, cmd.immediate_byte_count};
                    s_d.state = st_req;
                end
            end
            st_req: begin
                // Update forms with a zero or aliased base are refused without writes
                if (is_update(s_q.cmd.op) && (s_q.cmd.base_register == REG_ZERO
                        || s_q.cmd.base_register == s_q.cmd.target_register)) begin
                    s_d.invalid_form = 1'b1;
                    s_d.done = 1'b1;
                    s_d.cmd_ready = 1'b1;
                    s_d.state = st_idle;
                end else begin
                    s_d.addr = effective_address;
                    s_d.mem_valid = 1'b1;
                    s_d.mem_req.addr = effective_address;
                    s_d.mem_req.size_m1 = (s_q.cmd.op inside {op_lmw, op_lswi}) ?
                        SIZE_WORD : SIZE_HALF;
                    s_d.state = st_wait;
                end
            end
            st_wait: begin
                if (abort) begin
                    // Partial writes stay; reissue restarts the whole instruction
                    s_d.mem_valid = 1'b0;
                    s_d.cmd_ready = 1'b1;
                    s_d.state = st_idle;
                end else if (mem_ack) begin
                    s_d.mem_valid = 1'b0;
                    s_d.wr_a.en = 1'b1;
                    s_d.wr_a.num = s_q.dest;
                    half = mem_rdata[31:16];
                    case (s_q.cmd.op)
                        op_lha, op_lhau, op_lhax, op_lhaux:
                            word = {{16{half[15]}}, half};
                        op_lhz, op_lhzu, op_lhzx, op_lhzux:
                            word = {16'h0000, half};
                        op_lhbrx:
                            word = {16'h0000, half[7:0], half[15:8]};
                        op_lmw:
                            word = mem_rdata;
                        op_lswi: begin
                            // First byte fetched lands in the top lane
                            word = mem_rdata;
                            for (int i = 0; i < 4; i++) begin
                                if (3'(i) >= n) begin
                                    word[31 - 8*i -: 8] = 8'h00;
                                end
                            end
                        end
                        default: word = WORD_ZERO;
                    endcase
                    s_d.wr_a.data = word;
                    // Base write-back uses the address latched before any data write
                    if (is_update(s_q.cmd.op)) begin
                        s_d.wr_b.en = 1'b1;
                        s_d.wr_b.num = s_q.cmd.base_register;
                        s_d.wr_b.data = s_q.addr;
                    end
                    s_d.condition_field_zero_write = is_xform(s_q.cmd.op)
                        && s_q.cmd.record_bit;
                    if (s_q.cmd.op == op_lmw && s_q.dest != REG_LAST) begin
                        s_d.dest = s_q.dest + 5'h01;
                        s_d.addr = s_q.addr + WORD_STEP;
                        s_d.mem_req.addr = s_q.addr + WORD_STEP;
                        s_d.mem_valid = 1'b1;
                    end else if (s_q.cmd.op == op_lswi && s_q.remain > WORD_BYTES) begin
                        s_d.remain = s_q.remain - WORD_BYTES;
                        s_d.dest = s_q.dest + 5'h01;
                        s_d.addr = s_q.addr + WORD_STEP;
                        s_d.mem_req.addr = s_q.addr + WORD_STEP;
                        s_d.mem_valid = 1'b1;
                    end else begin
                        s_d.done = 1'b1;
                        s_d.cmd_ready = 1'b1;
                        s_d.state = st_idle;
                    end
                end
            end
            default: s_d.state = st_idle;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign cmd_ready = s_q.cmd_ready;
    assign rd_base_num = s_q.rd_base_num;
    assign rd_index_num = s_q.rd_index_num;
    assign mem_valid = s_q.mem_valid;
    assign mem_req = s_q.mem_req;
    assign wr_a = s_q.wr_a;
    assign wr_b = s_q.wr_b;
    assign invalid_form = s_q.invalid_form;
    assign condition_field_zero_write = s_q.condition_field_zero_write;
    assign done = s_q.done;

    property p_sext;
        @(posedge clock) disable iff (!rst_n)
        (s_q.state == st_wait && mem_ack && !abort && s_q.cmd.op == op_lha)
        |=> wr_a.en && wr_a.data == {{16{$past(mem_rdata[31])}}, $past(mem_rdata[31:16])};
    endproperty
    a_sext: assert property (p_sext) else $error("sign extension wrong");

    property p_zext;
        @(posedge clock) disable iff (!rst_n)
        (s_q.state == st_wait && mem_ack && !abort && s_q.cmd.op == op_lhz)
        |=> wr_a.data[31:16] == 16'h0000;
    endproperty
    a_zext: assert property (p_zext) else $error("upper half not zero");

    property p_brev;
        @(posedge clock) disable iff (!rst_n)
        (s_q.state == st_wait && mem_ack && !abort && s_q.cmd.op == op_lhbrx)
        |=> wr_a.data == {16'h0000, $past(mem_rdata[23:16]), $past(mem_rdata[31:24])};
    endproperty
    a_brev: assert property (p_brev) else $error("byte reverse wrong");

    property p_invalid;
        @(posedge clock) disable iff (!rst_n)
        (s_q.state == st_req && is_update(s_q.cmd.op) && s_q.cmd.base_register == REG_ZERO)
        |=> invalid_form && !wr_a.en && !wr_b.en && !mem_valid;
    endproperty
    a_invalid: assert property (p_invalid) else $error("invalid update form ran");

    property p_wb;
        @(posedge clock) disable iff (!rst_n)
        wr_b.en |-> wr_a.en && wr_b.num != wr_a.num;
    endproperty
    a_wb: assert property (p_wb) else $error("write-back aliases target");

    property p_ea_zero;
        @(posedge clock) disable iff (!rst_n)
        (s_q.state == st_req && s_q.cmd.op == op_lswi && s_q.cmd.base_register == REG_ZERO)
        |=> mem_req.addr == WORD_ZERO;
    endproperty
    a_ea_zero: assert property (p_ea_zero) else $error("string address not zero");

    property p_wrap;
        @(posedge clock) disable iff (!rst_n)
        (wr_a.en && s_q.cmd.op == op_lswi && wr_a.num == REG_LAST && mem_valid)
        |-> s_q.dest == REG_ZERO;
    endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap to register zero");

    property p_fill;
        @(posedge clock) disable iff (!rst_n)
        (s_q.state == st_wait && mem_ack && !abort && s_q.cmd.op == op_lswi
            && s_q.remain == 6'h01)
        |=> wr_a.data[23:0] == 24'h000000 && done;
    endproperty
    a_fill: assert property (p_fill) else $error("string tail not cleared");

    property p_lmw_end;
        @(posedge clock) disable iff (!rst_n)
        (wr_a.en && s_q.cmd.op == op_lmw && done) |-> wr_a.num == REG_LAST;
    endproperty
    a_lmw_end: assert property (p_lmw_end) else $error("multiple ended early");

    property p_index_ea;
        @(posedge clock) disable iff (!rst_n)
        (s_q.state == st_req && is_xform(s_q.cmd.op) && s_q.cmd.base_register != REG_ZERO
            && s_q.cmd.base_register != s_q.cmd.target_register)
        |=> mem_req.addr == $past(rd_base_data) + $past(rd_index_data);
    endproperty
    a_index_ea: assert property (p_index_ea) else $error("indexed address wrong");

    property p_disp_ea;
        @(posedge clock) disable iff (!rst_n)
        (s_q.state == st_req && s_q.cmd.op inside {op_lha, op_lhz})
        |=> mem_req.addr == {{16{s_q.cmd.displacement[15]}}, s_q.cmd.displacement}
            + ((s_q.cmd.base_register == REG_ZERO) ? WORD_ZERO : $past(rd_base_data));
    endproperty
    a_disp_ea: assert property (p_disp_ea) else $error("base plus offset wrong");

    property p_string_ea;
        @(posedge clock) disable iff (!rst_n)
        (s_q.state == st_req && s_q.cmd.op == op_lswi && s_q.cmd.base_register != REG_ZERO)
        |=> mem_req.addr == $past(rd_base_data);
    endproperty
    a_string_ea: assert property (p_string_ea) else $error("string address not base");

    property p_count_zero;
        @(posedge clock) disable iff (!rst_n)
        (s_q.state == st_idle && cmd_valid && cmd_ready && cmd.op == op_lswi
            && cmd.immediate_byte_count == '0)
        |=> s_q.state == st_req && s_q.remain == STRING_FULL_COUNT;
    endproperty
    a_count_zero: assert property (p_count_zero) else $error("zero count not full");

    property p_multi_word;
        @(posedge clock) disable iff (!rst_n)
        (s_q.state == st_wait && mem_ack && !abort && s_q.cmd.op == op_lmw)
        |=> wr_a.en && wr_a.num == $past(s_q.dest) && wr_a.data == $past(mem_rdata);
    endproperty
    a_multi_word: assert property (p_multi_word) else $error("word misplaced");

    property p_string_step;
        @(posedge clock) disable iff (!rst_n)
        (s_q.state == st_wait && mem_ack && !abort && s_q.cmd.op == op_lswi
            && s_q.remain > WORD_BYTES)
        |=> mem_valid && !done && wr_a.data == $past(mem_rdata)
            && mem_req.addr == $past(s_q.addr) + WORD_STEP;
    endproperty
    a_string_step: assert property (p_string_step) else $error("string step wrong");

    property p_abort;
        @(posedge clock) disable iff (!rst_n)
        (s_q.state == st_wait && abort)
        |=> !mem_valid && !wr_a.en && !done && cmd_ready;
    endproperty
    a_abort: assert property (p_abort) else $error("abort left work running");

    property p_update_wb;
        @(posedge clock) disable iff (!rst_n)
        (s_q.state == st_wait && mem_ack && !abort && is_update(s_q.cmd.op))
        |=> wr_b.en && wr_b.num == $past(s_q.cmd.base_register)
            && wr_b.data == $past(s_q.addr);
    endproperty
    a_update_wb: assert property (p_update_wb) else $error("update write-back wrong");

    property p_no_wb;
        @(posedge clock) disable iff (!rst_n)
        (s_q.state == st_wait && mem_ack && !abort && !is_update(s_q.cmd.op))
        |=> !wr_b.en;
    endproperty
    a_no_wb: assert property (p_no_wb) else $error("stray base write");

endmodule : load_halfword_multi_string_unit

/* src/load_unit_pkg.sv */
package load_unit_pkg;

    localparam int unsigned CLOCK_HZ = 50_000_000;
    localparam logic [4:0] REG_ZERO = 5'h00;
    localparam logic [4:0] REG_LAST = 5'h1f;
    localparam logic [5:0] STRING_FULL_COUNT = 6'h20;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [31:0] WORD_STEP = 32'h0000_0004;
    localparam logic [5:0] WORD_BYTES = 6'h04;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h3;

    typedef enum logic [3:0] {
        op_lha,
        op_lhau,
        op_lhax,
        op_lhaux,
        op_lhz,
        op_lhzu,
        op_lhzx,
        op_lhzux,
        op_lhbrx,
        op_lmw,
        op_lswi
    } load_op_t;

    typedef struct packed {
        load_op_t op;
        logic [4:0] target_register;
        logic [4:0] base_register;
        logic [4:0] index_register;
        logic [15:0] displacement;
        logic [4:0] immediate_byte_count;
        logic record_bit;
    } load_cmd_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [1:0] size_m1;
    } mem_req_t;

    typedef struct packed {
        logic en;
        logic [4:0] num;
        logic [31:0] data;
    } reg_write_t;

    typedef enum logic [1:0] {
        st_idle,
        st_req,
        st_wait
    } load_state_t;

endpackage : load_unit_pkg
